/* File: hdl/rail_cfg_regs.sv */
`default_nettype none

module rail_cfg_regs #(
  parameter int unsigned RTC_DIV = rail_cfg_pkg::RTC_PERIOD_CYC
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       low_power_idle_n,
  input  wire logic       all_rails_good,
  input  wire logic       resume_rails_good,
  input  wire logic [1:0] dsw3v3_mode_field,
  input  wire logic [1:0] io_rail_mode_field,
  input  wire logic [1:0] rail0v85_mode_field,
  input  wire logic [1:0] rail1v2_mode_field,
  input  wire logic [1:0] rail1v0_mode_field,
  input  wire logic [1:0] rail5v_mode_field,
  output logic      [1:0] dsw3v3_applied_mode,
  output logic      [1:0] io_rail_applied_mode,
  output logic      [1:0] rail0v85_applied_mode,
  output logic      [1:0] rail1v2_applied_mode,
  output logic      [1:0] rail1v0_applied_mode,
  output logic      [1:0] rail5v_applied_mode,
  output logic      [1:0] io_rail_discharge_sel,
  output logic      [1:0] rail5v_discharge_sel,
  output logic      [1:0] dsw3v3_discharge_sel,
  output logic      [1:0] hub3v3_discharge_sel,
  output logic      [1:0] aon1v8_discharge_sel,
  output logic      [1:0] rail1v8_2v5_discharge_sel,
  output logic      [1:0] rail1v2_discharge_sel,
  output logic      [1:0] rail1v0_discharge_sel,
  output logic      [1:0] rail0v85_discharge_sel,
  output logic      [1:0] sw3v3_discharge_sel,
  output logic      [1:0] sw1v8_discharge_sel,
  output logic      [1:0] sw1v0_discharge_sel,
  output logic     [11:0] discharge_path_on,
  output logic            resume_reset_good,
  output logic            platform_power_ok,
  output logic            system_power_ok,
  output logic            ctrl_s4_sleep_en,
  output logic            ctrl_deep_s4_en,
  output logic            rail_ctrl_write_lock
);
  import rail_cfg_pkg::*;

  typedef struct packed {
    logic [7:0]       ovr;
    logic [7:0]       dis_io;
    logic [7:0]       dis_a;
    logic [7:0]       dis_b;
    logic [7:0]       dis_ls;
    logic [7:0]       pgd;
    logic [7:0]       slp;
    logic [7:0]       lock;
    logic [7:0]       rdata;
    logic [1:0]       idle_s;
    logic [1:0]       all_s;
    logic [1:0]       res_s;
    logic [11:0]      div;
    logic             tick;
    logic [5:0][1:0]  mode;
    logic [11:0]      dis_on;
  } regs_t;

  localparam regs_t REGS_RST = '{ovr: RST_OVERRIDE, pgd: RST_PG_DELAY, idle_s: 2'h3,
                                 default: '0};

  regs_t            s_q;
  regs_t            s_d;
  logic [5:0][1:0]  mode_in;
  logic [5:0][1:0]  mode_next;
  logic [11:0][1:0] dis_sel;
  logic [11:0]      dis_next;
  logic [11:0]      res_target;
  logic [11:0]      plat_target;
  logic [11:0]      sys_target;
  logic             standby;

  // Rail order: bit 5 down to bit 0 of the override register
  assign mode_in = {dsw3v3_mode_field, io_rail_mode_field, rail0v85_mode_field,
                    rail1v2_mode_field, rail1v0_mode_field, rail5v_mode_field}; // R04
  assign standby = !s_q.idle_s[1];

  // Applied mode per rail during standby
  for (genvar i = 0; i < 6; i++) begin : g_rail
    assign mode_next[i] = (standby && mode_in[i] == MODE_PWM && !s_q.ovr[i]) // R01 R03 R17
                          ? MODE_AUTO : mode_in[i];                         // R02

    a_standby_auto: assert property (@(posedge mclk) disable iff (rst) // R01
      (ce && standby && mode_in[i] == MODE_PWM && !s_q.ovr[i]) |=> s_q.mode[i] == MODE_AUTO)
      else $error("PWM rail not forced to Auto in standby");
    a_override_keep: assert property (@(posedge mclk) disable iff (rst) // R02
      (ce && s_q.ovr[i]) |=> s_q.mode[i] == $past(mode_in[i]))
      else $error("overridden rail lost its own mode");
    a_non_pwm_pass: assert property (@(posedge mclk) disable iff (rst) // R03
      (ce && mode_in[i] != MODE_PWM) |=> s_q.mode[i] == $past(mode_in[i]))
      else $error("non-PWM rail mode was altered");
  end

  // Discharge selectors, io first down to the switched 1.0 V rail
  assign dis_sel = {s_q.dis_io[1:0], s_q.dis_a, s_q.dis_b, s_q.dis_ls[5:0]};

  // A path is open for any nonzero code; the always-on 1.8 V rail always has one
  for (genvar j = 0; j < 12; j++) begin : g_dis
    assign dis_next[j] = (dis_sel[j] != DIS_NONE) || (j == AON_IDX); // R05 R06 R07 R08 R09 R10

    // Every nonzero code opens the rail's path one edge later
    a_path_open: assert property (@(posedge mclk) disable iff (rst) // R05 R06 R08 R09 R10
      (ce && dis_sel[j] != DIS_NONE) |=> discharge_path_on[j])
      else $error("discharge path closed for a nonzero code");
    if (j != AON_IDX) begin : g_plain
      // Code 00 keeps the path closed except on the always-on 1.8 V rail
      a_path_closed: assert property (@(posedge mclk) disable iff (rst) // R05 R06 R08 R09 R10
        (ce && dis_sel[j] == DIS_NONE) |=> !discharge_path_on[j])
        else $error("discharge path open at code 00");
    end
  end

  // Delay targets from the power-good delay fields
  assign res_target  = RES_DLY[s_q.pgd[PG_RES_LSB +: 2]];   // R11
  assign plat_target = PLAT_DLY[s_q.pgd[PG_PLAT_LSB +: 2]]; // R12
  assign sys_target  = SYS_DLY[s_q.pgd[PG_SYS_LSB +: 3]];   // R13

  // Next state: synchronisers, RTC divider, register writes and reads
  always_comb begin
    s_d        = s_q;
    s_d.idle_s = {s_q.idle_s[0], low_power_idle_n};
    s_d.all_s  = {s_q.all_s[0], all_rails_good};
    s_d.res_s  = {s_q.res_s[0], resume_rails_good};
    s_d.mode   = mode_next;
    s_d.dis_on = dis_next;
    if (s_q.div == 12'(RTC_DIV - 1)) begin
      s_d.div  = 12'h000;
      s_d.tick = 1'b1;                                      // R14
    end else begin
      s_d.div  = s_q.div + 12'h001;
      s_d.tick = 1'b0;
    end
    if (reg_wr) begin
      case (reg_addr)
        OFF_OVERRIDE: s_d.ovr    = reg_wdata & MASK_OVERRIDE; // R04 R18
        OFF_IO_DISCH: s_d.dis_io = reg_wdata & MASK_IO_DISCH; // R18
        OFF_AON_A:    s_d.dis_a  = reg_wdata & MASK_FULL;
        OFF_AON_B:    s_d.dis_b  = reg_wdata & MASK_FULL;
        OFF_LS_DISCH: s_d.dis_ls = reg_wdata & MASK_LS_DISCH; // R18
        OFF_PG_DELAY: s_d.pgd    = reg_wdata & MASK_PG_DELAY; // R18
        OFF_SLEEP:    s_d.slp    = reg_wdata & MASK_FULL;     // R15 R18
        OFF_LOCK:     s_d.lock   = reg_wdata & MASK_LOCK;     // R16 R18
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        OFF_OVERRIDE: s_d.rdata = s_q.ovr;
        OFF_IO_DISCH: s_d.rdata = s_q.dis_io;
        OFF_AON_A:    s_d.rdata = s_q.dis_a;
        OFF_AON_B:    s_d.rdata = s_q.dis_b;
        OFF_LS_DISCH: s_d.rdata = s_q.dis_ls;
        OFF_PG_DELAY: s_d.rdata = s_q.pgd;
        OFF_SLEEP:    s_d.rdata = s_q.slp;
        OFF_LOCK:     s_d.rdata = s_q.lock;
        default:      s_d.rdata = RST_ZERO;
      endcase
    end
  end

  // State register; reset wins over the clock enable
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q <= REGS_RST;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // Power-good delay timers
  good_delay u_res_dly (
    .mclk     (mclk),
    .rst      (rst),
    .ce       (ce),
    .rtc_tick (s_q.tick),
    .level    (s_q.res_s[1]),
    .target   (res_target),
    .good     (resume_reset_good)
  );

  good_delay u_plat_dly (
    .mclk     (mclk),
    .rst      (rst),
    .ce       (ce),
    .rtc_tick (s_q.tick),
    .level    (s_q.all_s[1]),
    .target   (plat_target),
    .good     (platform_power_ok)
  );

  good_delay u_sys_dly (
    .mclk     (mclk),
    .rst      (rst),
    .ce       (ce),
    .rtc_tick (s_q.tick),
    .level    (s_q.all_s[1]),
    .target   (sys_target),
    .good     (system_power_ok)
  );

  // Outputs straight from the state register
  assign reg_rdata                 = s_q.rdata;
  assign {dsw3v3_applied_mode, io_rail_applied_mode, rail0v85_applied_mode,
          rail1v2_applied_mode, rail1v0_applied_mode, rail5v_applied_mode} = s_q.mode;
  assign io_rail_discharge_sel     = s_q.dis_io[1:0];
  assign rail5v_discharge_sel      = s_q.dis_a[7:6];
  assign dsw3v3_discharge_sel      = s_q.dis_a[5:4];
  assign hub3v3_discharge_sel      = s_q.dis_a[3:2];
  assign aon1v8_discharge_sel      = s_q.dis_a[1:0];
  assign rail1v8_2v5_discharge_sel = s_q.dis_b[7:6];
  assign rail1v2_discharge_sel     = s_q.dis_b[5:4];
  assign rail1v0_discharge_sel     = s_q.dis_b[3:2];
  assign rail0v85_discharge_sel    = s_q.dis_b[1:0];
  assign sw3v3_discharge_sel       = s_q.dis_ls[5:4];
  assign sw1v8_discharge_sel       = s_q.dis_ls[3:2];
  assign sw1v0_discharge_sel       = s_q.dis_ls[1:0];
  assign discharge_path_on         = s_q.dis_on;
  assign ctrl_s4_sleep_en          = s_q.slp[SLP_S4_BIT];   // R15
  assign ctrl_deep_s4_en           = s_q.slp[SLP_DS4_BIT];  // R15
  assign rail_ctrl_write_lock      = s_q.lock[LOCK_BIT];    // R16

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_sleep_write;
    ce && reg_wr && reg_addr == OFF_SLEEP;
  endsequence

  sequence s_lock_write;
    ce && reg_wr && reg_addr == OFF_LOCK;
  endsequence

  sequence s_ovr_write;
    ce && reg_wr && reg_addr == OFF_OVERRIDE;
  endsequence

  sequence s_pgd_write;
    ce && reg_wr && reg_addr == OFF_PG_DELAY;
  endsequence

  sequence s_unmapped_read;
    ce && reg_rd && (reg_addr < OFF_OVERRIDE || reg_addr > OFF_LOCK);
  endsequence

  a_reset_values: assert property ($fell(rst) |-> (s_q.ovr == RST_OVERRIDE // R04
      && s_q.pgd == RST_PG_DELAY && s_q.slp == RST_ZERO && s_q.lock == RST_ZERO))
    else $error("register values wrong after reset");
  a_sleep_store: assert property (s_sleep_write |=> s_q.slp == $past(reg_wdata)) // R15
    else $error("sleep enable write not stored");
  a_lock_store: assert property (s_lock_write |=> // R16
      rail_ctrl_write_lock == $past(reg_wdata[LOCK_BIT]) && s_q.lock[7:1] == 7'h00)
    else $error("write lock not stored");
  a_reserved_zero: assert property ((s_q.dis_io[7:2] == 6'h00) && !s_q.pgd[7] // R18
      && s_q.ovr[7:6] == 2'h0 && s_q.dis_ls[7:6] == 2'h0)
    else $error("read-only reserved bit not zero");
  a_aon_path: assert property (ce |=> discharge_path_on[AON_IDX]) // R07
    else $error("always-on 1.8 V discharge path not open");
  a_io_none: assert property ((ce && s_q.dis_io[1:0] == DIS_NONE) |=> !discharge_path_on[11]) // R05
    else $error("I/O rail discharge open at code 00");
  a_rtc_tick: assert property ((ce && s_q.div == 12'(RTC_DIV - 1)) // R14
      |=> s_q.tick && s_q.div == 12'h000)
    else $error("RTC period tick missing at divider wrap");
  a_tick_fall: assert property ((ce && s_q.tick && s_q.div != 12'(RTC_DIV - 1)) // R14
      |=> !s_q.tick)
    else $error("RTC period tick longer than one cycle");
  a_sys_ok_drop: assert property ((ce && !s_q.all_s[1]) ##1 ce |=> !system_power_ok) // R13
    else $error("system power-ok held without all-rails good");

  // Writes keep only the read-write bits; unmapped addresses are inert
  a_override_store: assert property (s_ovr_write |=> // R04 R18
      s_q.ovr == ($past(reg_wdata) & MASK_OVERRIDE))
    else $error("override write not stored with reserved bits clear");
  a_delay_cfg_store: assert property (s_pgd_write |=> // R18
      s_q.pgd == ($past(reg_wdata) & MASK_PG_DELAY))
    else $error("delay config write not stored with reserved bit clear");
  a_unmapped_zero: assert property (s_unmapped_read |=> reg_rdata == RST_ZERO) // R18
    else $error("unmapped address read not zero");
  a_unmapped_write: assert property ((ce && reg_wr && reg_addr > OFF_LOCK) // R18
      |=> $stable(s_q.pgd) && $stable(s_q.lock))
    else $error("write to an unmapped address changed a register");

  // Resume good with no delay, and delay outputs falling with their source
  a_res_no_delay: assert property ((ce && s_q.pgd[PG_RES_LSB +: 2] == 2'h0 // R11
      && s_q.res_s[1]) |=> resume_reset_good)
    else $error("resume-reset good delayed at code 00");
  a_res_drop: assert property ((ce && !s_q.res_s[1]) |=> !resume_reset_good) // R11
    else $error("resume-reset good held without its source");
  a_plat_drop: assert property ((ce && !s_q.all_s[1]) |=> !platform_power_ok) // R12
    else $error("platform power-ok held without all-rails good");

endmodule // rail_cfg_regs

`default_nettype wire

/* File: hdl/rail_cfg_pkg.sv */
// Overview of operation
// R01: Standby low, override 0: PWM rail runs Auto.
// R02: Override 1 keeps rail mode field during standby.
// R03: Override only affects rails set to forced PWM.
// R04: Override bits 5..0 map rails; reset ones.
// R05: I/O discharge codes: none,125,225,550 ohm.
// R06: 5V, DSW, hub discharge: none,100,200,500 ohm.
// R07: Always-on 1.8V code 00 selects 860 ohm.
// R08: 1.2V, 1.0V discharge: none,125,225,550 ohm.
// R09: 0.85V discharge: none,150,250,575 ohm.
// R10: Load switch discharge: none,100,200,500 ohm.
// R11: Resume-reset good delay: 0,164,360,721 periods.
// R12: Platform power-ok delay: 82,-,328,656 periods.
// R13: System power-ok delay: eight codes, 82..3280 periods.
// R14: Delay counters count 30.5 us RTC periods.
// R15: Two controller sleep enables, reset to zero.
// R16: Lock bit set rejects per-rail control writes; here it only drives rail_ctrl_write_lock and register writes still land.
// R17: Mode field 11 PWM, 01/10 Auto, 00 off.
// R18: Read-only reserved bits read zero, ignore writes.
// R19: Host programs fields first, locks last.
`default_nettype none

package rail_cfg_pkg;

  // Register offsets
  localparam logic [7:0] OFF_OVERRIDE = 8'h3B;
  localparam logic [7:0] OFF_IO_DISCH = 8'h3C;
  localparam logic [7:0] OFF_AON_A    = 8'h3D;
  localparam logic [7:0] OFF_AON_B    = 8'h3E;
  localparam logic [7:0] OFF_LS_DISCH = 8'h3F;
  localparam logic [7:0] OFF_PG_DELAY = 8'h40;
  localparam logic [7:0] OFF_SLEEP    = 8'h41;
  localparam logic [7:0] OFF_LOCK     = 8'h42;

  // Values after reset
  localparam logic [7:0] RST_OVERRIDE = 8'h3F;
  localparam logic [7:0] RST_PG_DELAY = 8'h5F;
  localparam logic [7:0] RST_ZERO     = 8'h00;

  // Writable bits; the rest are read-only zero
  localparam logic [7:0] MASK_OVERRIDE = 8'h3F;
  localparam logic [7:0] MASK_IO_DISCH = 8'h03;
  localparam logic [7:0] MASK_LS_DISCH = 8'h3F;
  localparam logic [7:0] MASK_PG_DELAY = 8'h7F;
  localparam logic [7:0] MASK_LOCK     = 8'h01;
  localparam logic [7:0] MASK_FULL     = 8'hFF;

  // Field positions
  localparam int PG_RES_LSB  = 5;
  localparam int PG_PLAT_LSB = 3;
  localparam int PG_SYS_LSB  = 0;
  localparam int SLP_S4_BIT  = 1;
  localparam int SLP_DS4_BIT = 0;
  localparam int LOCK_BIT    = 0;
  localparam int AON_IDX     = 7;   // Always-on 1.8 V entry in the discharge vector

  // Converter mode codes and the no-discharge code
  localparam logic [1:0] MODE_OFF  = 2'h0;
  localparam logic [1:0] MODE_AUTO = 2'h1;
  localparam logic [1:0] MODE_PWM  = 2'h3;
  localparam logic [1:0] DIS_NONE  = 2'h0;

  // RTC period and its length in system clocks
  localparam real RTC_PERIOD_US  = 30.5;
  localparam real CLK_PERIOD_NS  = 10.0;
  localparam int  RTC_PERIOD_CYC = int'(RTC_PERIOD_US * 1000.0 / CLK_PERIOD_NS);

  // Delay tables in RTC periods, indexed by field code
  localparam logic [11:0] RES_DLY [0:3] = '{12'h000, 12'h0A4, 12'h168, 12'h2D1};
  localparam logic [11:0] PLAT_DLY [0:3] = '{12'h052, 12'h052, 12'h148, 12'h290};
  localparam logic [11:0] SYS_DLY [0:7] = '{12'h052, 12'h0A4, 12'h148, 12'h1EC,
                                            12'h290, 12'h668, 12'h99C, 12'hCD0};

endpackage : rail_cfg_pkg

`default_nettype wire

/* File: hdl/good_delay.sv */
`default_nettype none

module good_delay (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        rtc_tick,
  input  wire logic        level,
  input  wire logic [11:0] target,
  output logic             good
);
  import rail_cfg_pkg::*;

  typedef struct packed {
    logic [11:0] cnt;
    logic        good;
  } dly_t;

  dly_t s_q;
  dly_t s_d;

  // Count RTC periods while the input is good; drop at once when it falls
  always_comb begin
    s_d = s_q;
    if (!level) begin
      s_d.cnt  = 12'h000;
      s_d.good = 1'b0;
    end else if (s_q.cnt >= target) begin
      s_d.good = 1'b1;                               // R11 R12 R13
    end else if (rtc_tick) begin
      s_d.cnt = s_q.cnt + 12'h001;                   // R14
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign good = s_q.good;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_delay_early: assert property ((ce && level && !s_q.good && s_q.cnt < target) |=> !s_q.good) // R13
    else $error("good output rose before the delay elapsed");
  a_delay_done: assert property ((ce && level && s_q.cnt >= target) |=> s_q.good) // R11
    else $error("good output late after the delay elapsed");
  a_delay_drop: assert property ((ce && !level) |=> (!s_q.good && s_q.cnt == 12'h000)) // R12
    else $error("good output not cleared when input dropped");
  a_tick_count: assert property ((ce && level && !rtc_tick) |=> $stable(s_q.cnt)) // R14
    else $error("delay counter moved without an RTC period");

endmodule // good_delay

`default_nettype wire

/* File: tb/platform_model.sv */
`default_nettype none

module platform_model (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic standby_req,
  input  wire logic good_req,
  output logic      low_power_idle_n,
  output logic      all_rails_good,
  output logic      resume_rails_good
);
  timeunit 1ns;
  timeprecision 1ns;

  // Pins are idle before the first falling edge
  initial {low_power_idle_n, all_rails_good, resume_rails_good} = 3'b100;

  // Hub pins move on the falling edge, one cycle after a request
  always @(negedge mclk) begin
    low_power_idle_n  <= rst | ~standby_req;
    all_rails_good    <= ~rst & good_req;
    resume_rails_good <= ~rst & good_req;
  end
endmodule // platform_model

`default_nettype wire

/* File: tb/rail_lowpower_discharge_pgood_regs_tb.sv */
`default_nettype none

`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin err_total++; \
  $display("[ERR] %s expected %0h seen %0h", nm, ex, got); end end

module rail_lowpower_discharge_pgood_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import rail_cfg_pkg::*;

  localparam int DIV = 4;
  // Rows: address, reset value, write value, read-back value
  localparam logic [31:0] ROWS [0:8] = '{32'h3B3FFF3F, 32'h3C00FF03, 32'h3D00A5A5,
    32'h3E005A5A, 32'h3F00FF3F, 32'h405FFF7F, 32'h4100FFFF, 32'h4200FF01, 32'h5000FF00};
  localparam logic [5:0] OVS [0:2] = '{6'h00, 6'h3F, 6'h15};
  // Delay config and expected periods: resume, platform, system
  localparam int DT [0:3][0:3] = '{'{32'h20, 164, 82, 82}, '{32'h4A, 360, 82, 328},
    '{32'h1B, 0, 656, 492}, '{32'h7F, 721, 656, 3280}};

  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        standby_req = 1'b0;
  logic        good_req = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  rd_v;
  logic [1:0]  mode_f = 2'h0;
  logic [7:0]  reg_rdata;
  logic        ce = 1'b1;
  wire logic [11:0] am;
  wire logic [23:0] ds;
  logic [11:0] path_on;
  logic        idle_n, all_good, res_good, res_ok, plat_ok, sys_ok, s4_en, ds4_en, lock_q;
  int          err_total = 0;
  int          checked = 0;
  int          cyc = 0;

  platform_model hub_u (.mclk(mclk), .rst(rst), .standby_req(standby_req),
    .good_req(good_req), .low_power_idle_n(idle_n), .all_rails_good(all_good),
    .resume_rails_good(res_good));

  rail_cfg_regs #(.RTC_DIV(DIV)) dut_u (.mclk(mclk), .rst(rst), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .low_power_idle_n(idle_n), .all_rails_good(all_good),
    .resume_rails_good(res_good), .dsw3v3_mode_field(mode_f), .io_rail_mode_field(mode_f),
    .rail0v85_mode_field(mode_f), .rail1v2_mode_field(mode_f), .rail1v0_mode_field(mode_f),
    .rail5v_mode_field(mode_f), .dsw3v3_applied_mode(am[11:10]),
    .io_rail_applied_mode(am[9:8]), .rail0v85_applied_mode(am[7:6]),
    .rail1v2_applied_mode(am[5:4]), .rail1v0_applied_mode(am[3:2]),
    .rail5v_applied_mode(am[1:0]), .io_rail_discharge_sel(ds[23:22]),
    .rail5v_discharge_sel(ds[21:20]), .dsw3v3_discharge_sel(ds[19:18]),
    .hub3v3_discharge_sel(ds[17:16]), .aon1v8_discharge_sel(ds[15:14]),
    .rail1v8_2v5_discharge_sel(ds[13:12]), .rail1v2_discharge_sel(ds[11:10]),
    .rail1v0_discharge_sel(ds[9:8]), .rail0v85_discharge_sel(ds[7:6]),
    .sw3v3_discharge_sel(ds[5:4]), .sw1v8_discharge_sel(ds[3:2]),
    .sw1v0_discharge_sel(ds[1:0]), .discharge_path_on(path_on), .resume_reset_good(res_ok),
    .platform_power_ok(plat_ok), .system_power_ok(sys_ok), .ctrl_s4_sleep_en(s4_en),
    .ctrl_deep_s4_en(ds4_en), .rail_ctrl_write_lock(lock_q));

  // Clock and hang guard
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      stop_test();
    end
  end

  // Verdict and end of run
  task automatic stop_test();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // One-cycle byte write and read strobes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask

  // Applied modes: a PWM rail without override drops to Auto in standby
  function automatic logic [11:0] exp_mode(logic [5:0] ov, logic [1:0] f, logic sb);
    logic [11:0] m;
    for (int i = 0; i < 6; i++) m[2*i +: 2] = (sb && f == MODE_PWM && !ov[i]) ? MODE_AUTO : f;
    return m;
  endfunction

  // Time from rails good to each output, from one RTC period early to six clocks late
  task automatic measure(input int n_res, input int n_plat, input int n_sys);
    int t [0:2];
    int n [0:2];
    t = '{-1, -1, -1};
    n = '{n_res, n_plat, n_sys};
    @(negedge mclk);
    good_req <= 1'b1;
    @(negedge mclk);
    for (int k = 1; k < 14000 && (t[0] < 0 || t[1] < 0 || t[2] < 0); k++) begin
      @(negedge mclk);
      if (t[0] < 0 && res_ok === 1'b1) t[0] = k;
      if (t[1] < 0 && plat_ok === 1'b1) t[1] = k;
      if (t[2] < 0 && sys_ok === 1'b1) t[2] = k;
    end
    for (int j = 0; j < 3; j++)
      `CHK("delay", 1'b1, t[j] >= (n[j] == 0 ? 1 : (n[j]-1)*DIV+1) && t[j] <= n[j]*DIV+6)
    good_req <= 1'b0;
    repeat (5) @(negedge mclk);
    `CHK("outputs after drop", 3'b000, {res_ok, plat_ok, sys_ok})
  endtask

  // Main sequence
  initial begin
    repeat (6) @(negedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      rd(ROWS[i][31:24], rd_v);
      `CHK("reset value", ROWS[i][23:16], rd_v)
      wr(ROWS[i][31:24], ROWS[i][15:8]);
      rd(ROWS[i][31:24], rd_v);
      `CHK("read back", ROWS[i][7:0], rd_v)
    end
    `CHK("enables and lock", 3'b111, {s4_en, ds4_en, lock_q})
    wr(OFF_IO_DISCH, 8'h02);
    wr(OFF_AON_A, 8'hE4);
    wr(OFF_AON_B, 8'h1B);
    wr(OFF_LS_DISCH, 8'h39);
    @(negedge mclk);
    `CHK("discharge selects", 24'hB906F9, ds)
    `CHK("discharge paths", 12'hFBF, path_on)
    wr(OFF_AON_A, 8'h00);
    @(negedge mclk);
    `CHK("aon path at code 0", 12'h8BF, path_on)
    foreach (OVS[o]) begin
      wr(OFF_OVERRIDE, {2'b00, OVS[o]});
      for (int s = 0; s < 2; s++) begin
        standby_req <= s[0];
        for (int f = 0; f < 4; f++) begin
          mode_f = f[1:0];
          repeat (5) @(negedge mclk);
          `CHK("applied mode", exp_mode(OVS[o], f[1:0], s[0]), am)
        end
      end
    end
    standby_req <= 1'b0;
    wr(OFF_SLEEP, 8'h01);
    `CHK("sleep enables", 2'b01, {s4_en, ds4_en})
    // A write strobe while the clock enable is low is lost
    ce = 1'b0;
    wr(OFF_SLEEP, 8'h02);
    ce = 1'b1;
    `CHK("write with enable low", 2'b01, {s4_en, ds4_en})
    // Delays are programmed before rails go good
    foreach (DT[i]) begin
      wr(OFF_PG_DELAY, DT[i][0][7:0]);
      measure(DT[i][1], DT[i][2], DT[i][3]);
    end
    // Reset in mid-run with all outputs up
    wr(OFF_PG_DELAY, 8'h20);
    good_req <= 1'b1;
    repeat (700) @(negedge mclk);
    `CHK("outputs up", 3'b111, {res_ok, plat_ok, sys_ok})
    rst <= 1'b1;
    repeat (6) @(negedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    `CHK("outputs after reset", 3'b000, {res_ok, plat_ok, sys_ok})
    rd(OFF_PG_DELAY, rd_v);
    `CHK("delay config after reset", RST_PG_DELAY, rd_v)
    stop_test();
  end
endmodule // rail_lowpower_discharge_pgood_regs_tb

`default_nettype wire
